/* hw/ocmac_pkg.sv */
// Package for the overcurrent monitor and amplifier calibration block.
// Assumes a 50 MHz core clock and a plain single-cycle register port.
package ocmac_pkg;

    // --------
    // Clock and timing
    // --------
    localparam int CLK_MHZ = 50;
    localparam int DEGLITCH_NS = 4500;
    localparam int DEGLITCH_CYC = DEGLITCH_NS * CLK_MHZ / 1000;
    localparam int CAL_US = 500;
    localparam int CAL_CYC = CAL_US * CLK_MHZ;
    localparam int RETRY_MS = 4;
    localparam int RETRY_CYC = RETRY_MS * 1000 * CLK_MHZ;

    // --------
    // Register offsets
    // --------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_AMP = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_STRAP = 4'h4;
    localparam logic [3:0] ADDR_STATE = 4'h5;

    // --------
    // Field positions
    // --------
    // CTRL: [3:0] trip level, [5:4] fault mode, [6] low-side ref, [7] clear
    localparam int CTRL_LVL_LSB = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_LSREF_BIT = 6;
    localparam int CTRL_CLR_BIT = 7;
    // AMP: [1:0] gain, [2] unidirectional, [3] auto trigger, [4] ext cal
    localparam int AMP_GAIN_LSB = 0;
    localparam int AMP_UNI_BIT = 2;
    localparam int AMP_AUTO_BIT = 3;
    localparam int AMP_EXT_BIT = 4;
    // STATUS / MASK: [0] trip, [1] cal done, [2] retry done
    localparam int EV_TRIP = 0;
    localparam int EV_CAL = 1;
    localparam int EV_RETRY = 2;
    localparam int EV_W = 3;

    // --------
    // Reset values
    // --------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [4:0] RST_AMP = 5'h00;
    localparam logic [2:0] RST_MASK = 3'h0;
    localparam logic [3:0] LVL_MAX = 4'hf;

    // Fault mode codes
    localparam logic [1:0] MODE_LATCH = 2'h0;
    localparam logic [1:0] MODE_RETRY = 2'h1;
    localparam logic [1:0] MODE_REPORT = 2'h2;

    typedef enum { CAL_IDLE, CAL_RUN } ocmac_cal_t;

endpackage : ocmac_pkg

/* hw/ocmac_sync.sv */
// Two-flop synchroniser bank for asynchronous pin levels.
// Assumes the inputs are static-ish levels, not pulses.
module ocmac_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta;

    // Only the second stage is visible outside
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_q <= '0;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule : ocmac_sync

/* hw/ocmac_deglitch.sv */
// One overcurrent deglitch timer for one monitored transistor.
// Assumes a synchronised comparator level on i_over.
module ocmac_deglitch (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    input wire logic i_over,
    output logic o_trip
);
    logic [7:0] cnt;

    // Count while above; any dip restarts the interval
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 8'h00;
            o_trip <= 1'b0;
        end else begin
            o_trip <= 1'b0;
            if (!i_en || !i_over) begin
                cnt <= 8'h00;
            end else if (cnt == 8'(ocmac_pkg::DEGLITCH_CYC)) begin
                o_trip <= 1'b1;
                cnt <= 8'h00;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule : ocmac_deglitch

/* hw/ocmac_top.sv */
// Overcurrent monitor and shunt-amplifier calibration control.
// Assumes analog comparators per transistor, strap pins pre-decoded to
// level codes, and a single-cycle register port on I_CLK.
//
// Added by the designer: the register addresses and the plain strobed port.
module ocmac_top #(
    parameter int RETRY_CYCLES = ocmac_pkg::RETRY_CYC,
    parameter int CAL_CYCLES = ocmac_pkg::CAL_CYC
) (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_STRAP_VARIANT,
    input wire logic I_ENABLE_PIN,
    input wire logic [1:0] I_MODE_STRAP,
    input wire logic [1:0] I_GAIN_STRAP,
    input wire logic [2:0] I_GATE_CURRENT_STRAP,
    input wire logic [2:0] I_TRIP_LEVEL_STRAP,
    input wire logic I_CAL_PIN,
    input wire logic I_REF_READY,
    input wire logic [5:0] I_DS_OVER,
    input wire logic [5:0] I_GATE_ON,
    output logic [7:0] O_RDATA,
    output logic O_IRQ,
    output logic O_GATES_DISABLE,
    output logic O_FAULT_N,
    output logic [3:0] O_TRIP_LEVEL_CODE,
    output logic O_LOW_SIDE_REF_NEG,
    output logic [1:0] O_GAIN_CODE,
    output logic O_UNIDIRECTIONAL,
    output logic O_AMP_INPUT_SHORT,
    output logic O_CAL_BUSY,
    output logic [1:0] O_MODE_LATCHED,
    output logic [2:0] O_GATE_CURRENT_LATCHED,
    output logic O_ENABLE_LATCHED
);

    // --------
    // Reset release and pin synchronisers
    // --------
    logic rst_meta;
    logic rst_n;

    // Release is synchronous so no flop leaves reset on a split edge
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    localparam int SW = 26;
    logic [SW-1:0] pins_async;
    logic [SW-1:0] pins;

    assign pins_async = {I_STRAP_VARIANT, I_ENABLE_PIN, I_MODE_STRAP, I_GAIN_STRAP,
                         I_GATE_CURRENT_STRAP, I_TRIP_LEVEL_STRAP, I_CAL_PIN,
                         I_REF_READY, I_DS_OVER, I_GATE_ON};

    ocmac_sync #(.W(SW)) u_sync (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_d(pins_async),
        .o_q(pins)
    );

    wire s_variant = pins[25];
    wire s_enable = pins[24];
    wire [1:0] s_mode = pins[23:22];
    wire [1:0] s_gain = pins[21:20];
    wire [2:0] s_icur = pins[19:17];
    wire [2:0] s_vds = pins[16:14];
    wire s_cal_pin = pins[13];
    wire s_ref_ok = pins[12];
    wire [5:0] s_over = pins[11:6];
    wire [5:0] s_gate_on = pins[5:0];

    // --------
    // Power-up strap capture
    // --------
    // One capture after the synchronisers have filled; later edits ignored
    logic [1:0] cap_wait;
    logic captured;
    logic variant;
    logic [1:0] gain_strap;
    logic [2:0] vds_strap;

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cap_wait <= 2'h0;
            captured <= 1'b0;
        end else if (!captured) begin
            cap_wait <= cap_wait + 2'h1;
            captured <= (cap_wait == 2'h3);
        end
    end

    wire cap_now = !captured && (cap_wait == 2'h3);

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            variant <= 1'b0;
            O_ENABLE_LATCHED <= 1'b0;
            O_MODE_LATCHED <= 2'h0;
            gain_strap <= 2'h0;
            O_GATE_CURRENT_LATCHED <= 3'h0;
            vds_strap <= 3'h0;
        end else if (cap_now) begin
            variant <= s_variant;
            O_ENABLE_LATCHED <= s_enable;
            O_MODE_LATCHED <= s_mode;
            gain_strap <= s_gain;
            O_GATE_CURRENT_LATCHED <= s_icur;
            vds_strap <= s_vds;
        end
    end

    // Seven-level trip strap spread over the 16-step level code;
    // code 7 (tied high) turns the monitor off
    function automatic logic [3:0] strap_to_lvl(input logic [2:0] s);
        strap_to_lvl = {s, 1'b0} + {3'h0, s[2]};
    endfunction : strap_to_lvl

    // --------
    // Register file
    // --------
    logic [7:0] ctrl;
    logic [4:0] amp;
    logic [ocmac_pkg::EV_W-1:0] status;
    logic [ocmac_pkg::EV_W-1:0] mask;

    wire wr_ctrl = I_WR && (I_ADDR == ocmac_pkg::ADDR_CTRL);
    wire wr_amp = I_WR && (I_ADDR == ocmac_pkg::ADDR_AMP);
    wire wr_mask = I_WR && (I_ADDR == ocmac_pkg::ADDR_MASK);
    wire rd_status = I_RD && (I_ADDR == ocmac_pkg::ADDR_STATUS);
    wire clr_fault = wr_ctrl && I_WDATA[ocmac_pkg::CTRL_CLR_BIT];

    // Clear bit is self-clearing, never stored
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= ocmac_pkg::RST_CTRL;
            amp <= ocmac_pkg::RST_AMP;
            mask <= ocmac_pkg::RST_MASK;
        end else begin
            if (wr_ctrl)
                ctrl <= {1'b0, I_WDATA[6:0]};
            if (wr_amp)
                amp <= I_WDATA[4:0];
            if (wr_mask)
                mask <= I_WDATA[ocmac_pkg::EV_W-1:0];
        end
    end

    wire [1:0] fault_mode = variant ? ocmac_pkg::MODE_RETRY
                                    : ctrl[ocmac_pkg::CTRL_MODE_LSB +: 2];
    wire [3:0] lvl_sel = variant ? strap_to_lvl(vds_strap)
                                 : ctrl[ocmac_pkg::CTRL_LVL_LSB +: 4];
    wire low_side_reference_select_neg = !variant && ctrl[ocmac_pkg::CTRL_LSREF_BIT];
    wire [1:0] gain_sel = variant ? gain_strap : amp[ocmac_pkg::AMP_GAIN_LSB +: 2];
    wire uni_sel = !variant && amp[ocmac_pkg::AMP_UNI_BIT];
    wire ext_cal = variant ? s_cal_pin : (amp[ocmac_pkg::AMP_EXT_BIT] || s_cal_pin);
    wire mon_off = variant && (vds_strap == 3'h7);

    // --------
    // Overcurrent detection and fault response
    // --------
    logic [5:0] trip;

    // Only a transistor that is switched on is watched
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_mon
            ocmac_deglitch u_dg (
                .i_clk(I_CLK),
                .i_rst_n(rst_n),
                .i_en(s_gate_on[g] && !mon_off),
                .i_over(s_over[g]),
                .o_trip(trip[g])
            );
        end
    endgenerate

    wire any_trip = |trip;
    wire trip_acts = (fault_mode == ocmac_pkg::MODE_LATCH)
                  || (fault_mode == ocmac_pkg::MODE_RETRY);
    wire trip_reports = trip_acts || (fault_mode == ocmac_pkg::MODE_REPORT);

    logic shut;
    logic [31:0] retry_cnt;
    logic retry_done;

    // Latched mode waits for a clear; retry mode times out on its own
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            shut <= 1'b0;
            retry_cnt <= 32'h0;
            retry_done <= 1'b0;
        end else begin
            retry_done <= 1'b0;
            if (any_trip && trip_acts) begin
                shut <= 1'b1;
                retry_cnt <= 32'h0;
            end else if (shut && fault_mode == ocmac_pkg::MODE_RETRY) begin
                if (retry_cnt == 32'(RETRY_CYCLES - 1)) begin
                    shut <= 1'b0;
                    retry_done <= 1'b1;
                end else begin
                    retry_cnt <= retry_cnt + 32'h1;
                end
            end else if (shut && clr_fault) begin
                shut <= 1'b0;
            end
        end
    end

    logic report_flag;

    // Report-only mode pulls the fault line until software clears
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n)
            report_flag <= 1'b0;
        else if (any_trip && trip_reports)
            report_flag <= 1'b1;
        else if (clr_fault || retry_done)
            report_flag <= 1'b0;
    end

    // --------
    // Offset calibration sequencer
    // --------
    ocmac_pkg::ocmac_cal_t cal_state;
    logic [31:0] cal_cnt;
    logic powerup_pending;
    logic auto_prev;
    logic cal_done;

    wire auto_rise = amp[ocmac_pkg::AMP_AUTO_BIT] && !auto_prev;
    wire cal_start = (powerup_pending && s_ref_ok) || (!variant && auto_rise);

    // Edge detect on the stored bit, so rewriting one does nothing
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            auto_prev <= 1'b0;
            powerup_pending <= 1'b1;
        end else begin
            auto_prev <= amp[ocmac_pkg::AMP_AUTO_BIT];
            if (powerup_pending && s_ref_ok)
                powerup_pending <= 1'b0;
        end
    end

    // Fixed run length well inside the upper bound
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cal_state <= ocmac_pkg::CAL_IDLE;
            cal_cnt <= 32'h0;
            cal_done <= 1'b0;
        end else begin
            cal_done <= 1'b0;
            case (cal_state)
                ocmac_pkg::CAL_IDLE: begin
                    cal_cnt <= 32'h0;
                    if (cal_start)
                        cal_state <= ocmac_pkg::CAL_RUN;
                end
                ocmac_pkg::CAL_RUN: begin
                    if (cal_cnt == 32'(CAL_CYCLES / 2 - 1)) begin
                        cal_state <= ocmac_pkg::CAL_IDLE;
                        cal_done <= 1'b1;
                    end else begin
                        cal_cnt <= cal_cnt + 32'h1;
                    end
                end
                default: cal_state <= ocmac_pkg::CAL_IDLE;
            endcase
        end
    end

    wire cal_running = (cal_state == ocmac_pkg::CAL_RUN);

    // --------
    // Events, interrupt and readback
    // --------
    wire [ocmac_pkg::EV_W-1:0] ev = {retry_done, cal_done, any_trip && trip_reports};

    // A new event in the clearing read cycle survives
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n)
            status <= '0;
        else
            status <= (rd_status ? '0 : status) | ev;
    end

    wire [7:0] rd_mux =
        (I_ADDR == ocmac_pkg::ADDR_CTRL) ? ctrl :
        (I_ADDR == ocmac_pkg::ADDR_AMP) ? {3'h0, amp} :
        (I_ADDR == ocmac_pkg::ADDR_STATUS) ? {5'h0, status} :
        (I_ADDR == ocmac_pkg::ADDR_MASK) ? {5'h0, mask} :
        (I_ADDR == ocmac_pkg::ADDR_STRAP) ?
            {variant, O_ENABLE_LATCHED, O_MODE_LATCHED, gain_strap, 2'h0} :
        (I_ADDR == ocmac_pkg::ADDR_STATE) ?
            {4'h0, ext_cal, cal_running, report_flag, shut} : 8'h00;

    // All outputs registered
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_RDATA <= 8'h00;
            O_IRQ <= 1'b0;
            O_GATES_DISABLE <= 1'b0;
            O_FAULT_N <= 1'b1;
            O_TRIP_LEVEL_CODE <= 4'h0;
            O_LOW_SIDE_REF_NEG <= 1'b0;
            O_GAIN_CODE <= 2'h0;
            O_UNIDIRECTIONAL <= 1'b0;
            O_AMP_INPUT_SHORT <= 1'b0;
            O_CAL_BUSY <= 1'b0;
        end else begin
            O_RDATA <= I_RD ? rd_mux : 8'h00;
            O_IRQ <= |(status & mask);
            O_GATES_DISABLE <= shut;
            O_FAULT_N <= !(shut || report_flag);
            O_TRIP_LEVEL_CODE <= lvl_sel;
            O_LOW_SIDE_REF_NEG <= low_side_reference_select_neg;
            O_GAIN_CODE <= gain_sel;
            O_UNIDIRECTIONAL <= uni_sel;
            O_AMP_INPUT_SHORT <= cal_running || ext_cal;
            O_CAL_BUSY <= cal_running;
        end
    end

endmodule : ocmac_top

/* sim/ocmac_checker.sv */
// Port-level checks for the overcurrent monitor and calibration block.
// Assumes a bind onto ocmac_top; sees only that module's ports.
module ocmac_checker #(
    parameter int RETRY_CYCLES = 20,
    parameter int CAL_CYCLES = 40
) (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic [3:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_STRAP_VARIANT,
    input wire logic I_CAL_PIN,
    input wire logic [5:0] I_DS_OVER,
    input wire logic [5:0] I_GATE_ON,
    input wire logic [7:0] O_RDATA,
    input wire logic O_IRQ,
    input wire logic O_GATES_DISABLE,
    input wire logic O_FAULT_N,
    input wire logic [3:0] O_TRIP_LEVEL_CODE,
    input wire logic O_LOW_SIDE_REF_NEG,
    input wire logic [1:0] O_GAIN_CODE,
    input wire logic O_UNIDIRECTIONAL,
    input wire logic O_AMP_INPUT_SHORT,
    input wire logic O_CAL_BUSY,
    input wire logic [1:0] O_MODE_LATCHED,
    input wire logic [2:0] O_GATE_CURRENT_LATCHED,
    input wire logic O_ENABLE_LATCHED
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TRIP_RUN = 226;
    int over_run;
    int cal_run;
    int up_run;
    wire logic any_over = |(I_DS_OVER & I_GATE_ON);
    wire logic wr_ctrl = I_WR && I_ADDR == ocmac_pkg::ADDR_CTRL && !I_STRAP_VARIANT;
    wire logic wr_amp = I_WR && I_ADDR == ocmac_pkg::ADDR_AMP && !I_STRAP_VARIANT;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    // Pin run lengths; up_run saturates past strap capture
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            over_run <= 0;
            cal_run <= 0;
            up_run <= 0;
        end else begin
            over_run <= any_over ? over_run + 1 : 0;
            cal_run <= O_CAL_BUSY ? cal_run + 1 : 0;
            up_run <= (up_run < 15) ? up_run + 1 : up_run;
        end
    end

    property p_rdata_idle;
        !$past(I_RD) |-> O_RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_mask_off;
        I_WR && I_ADDR == ocmac_pkg::ADDR_MASK && I_WDATA[2:0] == 3'h0 |-> ##2 !O_IRQ;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq with mask cleared");
    property p_shut_fault;
        $rose(O_GATES_DISABLE) |-> ##[0:1] !O_FAULT_N;
    endproperty
    a_shut_fault: assert property (p_shut_fault) else $error("shutdown unreported");
    property p_deglitch;
        $fell(O_FAULT_N) |-> over_run >= TRIP_RUN;
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("trip before deglitch");
    property p_cal_short;
        O_CAL_BUSY |-> O_AMP_INPUT_SHORT;
    endproperty
    a_cal_short: assert property (p_cal_short) else $error("inputs open in cal");
    property p_cal_len;
        $fell(O_CAL_BUSY) |-> cal_run >= CAL_CYCLES / 2 - 1 && cal_run <= CAL_CYCLES;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("cal length wrong");
    property p_ext_pin;
        (up_run == 15 && I_CAL_PIN) [*5] |-> O_AMP_INPUT_SHORT;
    endproperty
    a_ext_pin: assert property (p_ext_pin) else $error("cal pin ignored");
    property p_ctrl_out;
        logic [7:0] v;
        (wr_ctrl, v = I_WDATA) |-> ##2 O_TRIP_LEVEL_CODE == v[3:0] && O_LOW_SIDE_REF_NEG == v[6];
    endproperty
    a_ctrl_out: assert property (p_ctrl_out) else $error("ctrl fields");
    property p_amp_out;
        logic [7:0] v;
        (wr_amp, v = I_WDATA) |-> ##2 {O_UNIDIRECTIONAL, O_GAIN_CODE} == v[2:0];
    endproperty
    a_amp_out: assert property (p_amp_out) else $error("amp fields");
    property p_strap_hold;
        up_run == 15 |-> $stable({O_MODE_LATCHED, O_GATE_CURRENT_LATCHED, O_ENABLE_LATCHED});
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");
    c_trip: cover property ($fell(O_FAULT_N));
    c_cal: cover property ($fell(O_CAL_BUSY));
    c_irq: cover property ($rose(O_IRQ));
endmodule : ocmac_checker

/* sim/ocmac_fet_model.sv */
// Behavioural half-bridge transistors feeding the monitor inputs.
// Assumes the bench commands shorts; a disabled driver turns all gates off.
module ocmac_fet_model (
    input wire logic i_clk,
    input wire logic i_gates_disable,
    input wire logic i_switch,
    input wire logic [5:0] i_short,
    output logic [5:0] o_gate_on,
    output logic [5:0] o_ds_over
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] phase = 6'h15;
    // Legs swap each cycle while switching, so a short never stays on long
    always @(posedge i_clk) begin
        phase <= i_switch ? ~phase : 6'h15;
    end
    // Only a conducting shorted leg shows drain-source above trip
    assign o_gate_on = i_gates_disable ? 6'h00 : phase;
    assign o_ds_over = i_short & o_gate_on;
endmodule : ocmac_fet_model

/* sim/tb_ocmac_top.sv */
// Self-checking bench for the overcurrent and calibration block.
// Assumes the transistor model drives the monitor pins; bench drives the rest.
module tb_ocmac_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RETRY = 20;
    localparam int CAL = 40;
    logic I_CLK = 1'b0;
    logic I_ARST_N = 1'b0;
    logic [3:0] I_ADDR = 4'h0;
    logic [7:0] I_WDATA = 8'h00;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    logic I_STRAP_VARIANT = 1'b0;
    logic I_ENABLE_PIN, I_CAL_PIN = 1'b0, I_REF_READY = 1'b0;
    logic [1:0] I_MODE_STRAP, I_GAIN_STRAP, O_GAIN_CODE, O_MODE_LATCHED, ms, gs;
    logic [2:0] I_GATE_CURRENT_STRAP, I_TRIP_LEVEL_STRAP, O_GATE_CURRENT_LATCHED, gc;
    logic [5:0] I_DS_OVER, I_GATE_ON, short_cmd = 6'h00;
    logic [7:0] O_RDATA, v, e;
    logic [3:0] O_TRIP_LEVEL_CODE;
    logic O_IRQ, O_GATES_DISABLE, O_FAULT_N, O_LOW_SIDE_REF_NEG, O_UNIDIRECTIONAL;
    logic O_AMP_INPUT_SHORT, O_CAL_BUSY, O_ENABLE_LATCHED, en, sw = 1'b0, rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int compares = 0;
    int n;

    always #10 I_CLK = ~I_CLK;

    ocmac_top #(.RETRY_CYCLES(RETRY), .CAL_CYCLES(CAL)) ocmac_top_i (.I_CLK, .I_ARST_N,
        .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_STRAP_VARIANT, .I_ENABLE_PIN, .I_MODE_STRAP,
        .I_GAIN_STRAP, .I_GATE_CURRENT_STRAP, .I_TRIP_LEVEL_STRAP, .I_CAL_PIN, .I_REF_READY,
        .I_DS_OVER, .I_GATE_ON, .O_RDATA, .O_IRQ, .O_GATES_DISABLE, .O_FAULT_N,
        .O_TRIP_LEVEL_CODE, .O_LOW_SIDE_REF_NEG, .O_GAIN_CODE, .O_UNIDIRECTIONAL,
        .O_AMP_INPUT_SHORT, .O_CAL_BUSY, .O_MODE_LATCHED, .O_GATE_CURRENT_LATCHED,
        .O_ENABLE_LATCHED);
    ocmac_fet_model ocmac_fet_model_i (.i_clk(I_CLK), .i_gates_disable(O_GATES_DISABLE),
        .i_switch(sw), .i_short(short_cmd), .o_gate_on(I_GATE_ON), .o_ds_over(I_DS_OVER));

    // --------
    // Bus tasks and checks
    // --------
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task automatic idle(input int c);
        repeat (c) @(posedge I_CLK);
    endtask : idle
    // Idle slot after each strobe; no double drive
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        idle(1);
        I_WR <= 1'b0;
        idle(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        exp_q.push_back(d);
        I_ADDR <= a;
        I_RD <= 1'b1;
        idle(1);
        I_RD <= 1'b0;
        idle(1);
    endtask : rd
    // Bounded wait; returns cycles taken
    task automatic wait_for(ref logic s, input logic lv, input int lim, output int c);
        c = 0;
        while (s !== lv && c < lim) begin
            idle(1);
            c++;
        end
    endtask : wait_for
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // Read data stand in the slot after the strobe
    always @(posedge I_CLK) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            chk(O_RDATA === e, "read data");
        end
        rd_seen <= I_RD;
    end

    // Run is a few thousand cycles; this cuts a hang
    initial begin
        idle(20000);
        mismatches++;
        results();
    end

    // --------
    // Main sequence
    // --------
    initial begin
        void'($urandom(29691));
        ms = 2'($urandom_range(3, 0));
        gs = 2'($urandom_range(3, 0));
        gc = 3'($urandom_range(6, 0));
        en = 1'($urandom_range(1, 0));
        I_MODE_STRAP = ms;
        I_GAIN_STRAP = gs;
        I_GATE_CURRENT_STRAP = gc;
        I_TRIP_LEVEL_STRAP = 3'($urandom_range(6, 0));
        I_ENABLE_PIN = en;
        idle(2);
        I_ARST_N <= 1'b1;
        idle(20);
        chk(O_CAL_BUSY === 1'b0 && O_FAULT_N === 1'b1, "early cal");
        I_MODE_STRAP <= ~ms;
        I_GATE_CURRENT_STRAP <= ~gc;
        I_ENABLE_PIN <= ~en;
        rd(ocmac_pkg::ADDR_STRAP, {1'b0, en, ms, gs, 2'h0});
        chk({O_MODE_LATCHED, O_GATE_CURRENT_LATCHED, O_ENABLE_LATCHED} === {ms, gc, en},
            "straps");
        rd(ocmac_pkg::ADDR_CTRL, ocmac_pkg::RST_CTRL);
        rd(ocmac_pkg::ADDR_AMP, {3'h0, ocmac_pkg::RST_AMP});
        rd(ocmac_pkg::ADDR_MASK, {5'h00, ocmac_pkg::RST_MASK});
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h00);
        // Reference comes up: power-up calibration, then clear-on-read
        I_REF_READY <= 1'b1;
        wait_for(O_CAL_BUSY, 1'b1, 10, n);
        chk(n < 10 && O_AMP_INPUT_SHORT === 1'b1, "power-up cal");
        wait_for(O_CAL_BUSY, 1'b0, CAL, n);
        chk(n < CAL, "cal length");
        rd(ocmac_pkg::ADDR_STATUS, 8'h02);
        rd(ocmac_pkg::ADDR_STATUS, 8'h00);
        chk(O_AMP_INPUT_SHORT === 1'b0, "inputs back");
        // Trip level ends then random fields
        for (int i = 0; i < 6; i++) begin
            v = i == 0 ? 8'h00 : i == 1 ? {4'h4, ocmac_pkg::LVL_MAX} : 8'($urandom_range(127, 0));
            wr(ocmac_pkg::ADDR_CTRL, v);
            rd(ocmac_pkg::ADDR_CTRL, v);
            chk(O_TRIP_LEVEL_CODE === v[3:0] && O_LOW_SIDE_REF_NEG === v[6], "ctrl");
        end
        // Every gain with both directions
        for (int g = 0; g < 8; g++) begin
            wr(ocmac_pkg::ADDR_AMP, 8'(g));
            rd(ocmac_pkg::ADDR_AMP, 8'(g));
            chk({O_UNIDIRECTIONAL, O_GAIN_CODE} === 3'(g), "gain");
        end
        wr(ocmac_pkg::ADDR_AMP, 8'h10);
        rd(ocmac_pkg::ADDR_STATE, 8'h08);
        chk(O_AMP_INPUT_SHORT === 1'b1, "ext cal bit");
        wr(ocmac_pkg::ADDR_AMP, 8'h00);
        I_CAL_PIN <= 1'b1;
        idle(6);
        chk(O_AMP_INPUT_SHORT === 1'b1, "cal pin");
        I_CAL_PIN <= 1'b0;
        idle(6);
        chk(O_AMP_INPUT_SHORT === 1'b0, "cal pin off");
        // Run-time calibration with bridges idle, unmasked done event
        wr(ocmac_pkg::ADDR_MASK, 8'h02);
        wr(ocmac_pkg::ADDR_AMP, 8'h08);
        wait_for(O_CAL_BUSY, 1'b1, 4, n);
        chk(n < 4 && O_AMP_INPUT_SHORT === 1'b1, "runtime cal");
        idle(CAL);
        chk(O_CAL_BUSY === 1'b0 && O_IRQ === 1'b1, "cal irq");
        wr(ocmac_pkg::ADDR_AMP, 8'h08);
        idle(3);
        chk(O_CAL_BUSY === 1'b0, "rewrite one");
        rd(ocmac_pkg::ADDR_STATUS, 8'h02);
        idle(2);
        chk(O_IRQ === 1'b0, "irq cleared");
        wr(ocmac_pkg::ADDR_AMP, 8'h00);
        wr(ocmac_pkg::ADDR_AMP, 8'h08);
        wait_for(O_CAL_BUSY, 1'b1, 4, n);
        chk(n < 4, "retrigger");
        idle(CAL);
        wr(ocmac_pkg::ADDR_MASK, 8'h00);
        idle(1);
        chk(O_IRQ === 1'b0, "masked");
        rd(ocmac_pkg::ADDR_STATUS, 8'h02);
        // Each fault mode: short while switching, then held on
        for (int m = 0; m < 4; m++) begin
            wr(ocmac_pkg::ADDR_CTRL, 8'(m * 16));
            short_cmd <= 6'h01;
            sw <= 1'b1;
            idle(300);
            chk(O_FAULT_N === 1'b1, "glitch trip");
            sw <= 1'b0;
            wait_for(O_FAULT_N, 1'b0, 260, n);
            chk(m == 3 ? n == 260 : n >= 226 && n < 240, "deglitch");
            idle(2);
            chk(O_GATES_DISABLE === (m < 2), "shutdown");
            short_cmd <= 6'h00;
            wait_for(O_FAULT_N, 1'b1, RETRY + 8, n);
            if (m == 1) chk(n > RETRY - 6 && n < RETRY + 8, "retry");
            if (m == 0) chk(O_GATES_DISABLE === 1'b1, "latched");
            rd(ocmac_pkg::ADDR_STATUS, m == 1 ? 8'h05 : m == 3 ? 8'h00 : 8'h01);
            wr(ocmac_pkg::ADDR_CTRL, 8'h80);
            idle(2);
            chk(O_FAULT_N === 1'b1 && O_GATES_DISABLE === 1'b0, "cleared");
        end
        // Second reset into the strap variant
        I_ARST_N <= 1'b0;
        I_STRAP_VARIANT <= 1'b1;
        idle(2);
        I_ARST_N <= 1'b1;
        idle(20);
        chk(O_GAIN_CODE === gs && O_TRIP_LEVEL_CODE === 2 * I_TRIP_LEVEL_STRAP
            + I_TRIP_LEVEL_STRAP[2], "variant");
        results();
    end
endmodule : tb_ocmac_top

bind ocmac_top ocmac_checker #(.RETRY_CYCLES(RETRY_CYCLES), .CAL_CYCLES(CAL_CYCLES))
    ocmac_checker_i (.I_CLK, .I_ARST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_STRAP_VARIANT,
    .I_CAL_PIN, .I_DS_OVER, .I_GATE_ON, .O_RDATA, .O_IRQ, .O_GATES_DISABLE, .O_FAULT_N,
    .O_TRIP_LEVEL_CODE, .O_LOW_SIDE_REF_NEG, .O_GAIN_CODE, .O_UNIDIRECTIONAL,
    .O_AMP_INPUT_SHORT, .O_CAL_BUSY, .O_MODE_LATCHED, .O_GATE_CURRENT_LATCHED,
    .O_ENABLE_LATCHED);
